// ### sbst_tap.sv
// boundary-scan test port of a pipelined sram, top level
// assumes tck/tms/tdi and the io ring arrive unsynchronised from pins;
// clk_i must run at least eight times faster than the test clock
//
// Summary of operation
// - five test-clock rises with mode select high reset the port only
// - power-up reset leaves serial output undriven
// - instruction picks exactly one register for the serial path
// - serial input sampled on tck rise, output changes on tck fall
// - instruction register is three bits, shifted serially when selected
// - instruction is identification after reset and in reset state
// - capture of instruction loads binary 01 into two low bits
// - bypass is one bit, the sole path under bypass in shift
// - boundary register captures io ring, then shifts in data shift
// - serial input enters the msb, serial output leaves the lsb
// - identification register captures a fixed 32-bit code and shifts it
// - shifted instruction takes effect only at instruction update
// - port never drives data to memory or io buffers, only captures the ring and forces outputs off
// - all-zero instruction samples like sample/preload, outputs off
// - sample-with-outputs-off shifts boundary register, outputs off
// - sample/preload snapshots all pin states at data capture
// - captured data shifts out while new data shifts in together
// - code 000 is the all-zero test, code 001 identification read
// - identification bit 0 reads as one
// - boundary register is 71 bits long
// - serial output driven only in shift states; tms and tdi default high, tck low
`timescale 1ns/1ns
`default_nettype none
`include "sbst_defs.svh"

module sbst_tap
    import sbst_pkg::*;
#(
    parameter int BSR_W = `SBST_BSR_W,
    parameter logic [`SBST_ID_W-1:0] ID_CODE = `SBST_ID_CODE
)
(
    // system
    input wire logic clk_i,
    input wire logic resetn_i,
    // test port pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // memory io ring
    input wire logic [BSR_W-1:0] io_ring_i,
    output logic mem_out_hiz_o
);

    // -----------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------
    logic tck_s1_q;
    logic tck_s2_q;
    logic tck_prev_q;
    logic tms_s1_q;
    logic tms_s2_q;
    logic tdi_s1_q;
    logic tdi_s2_q;
    logic [BSR_W-1:0] ring_s1_q;
    logic [BSR_W-1:0] ring_s2_q;

    // pins float high when unconnected, so tms and tdi sync stages reset high; tck stages reset low
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            tck_s1_q <= 1'h0;
            tck_s2_q <= 1'h0;
            tck_prev_q <= 1'h0;
            tms_s1_q <= 1'h1;
            tms_s2_q <= 1'h1;
            tdi_s1_q <= 1'h1;
            tdi_s2_q <= 1'h1;
        end
        else
        begin
            tck_s1_q <= tck_i;
            tck_s2_q <= tck_s1_q;
            tck_prev_q <= tck_s2_q;
            tms_s1_q <= tms_i;
            tms_s2_q <= tms_s1_q;
            tdi_s1_q <= tdi_i;
            tdi_s2_q <= tdi_s1_q;
        end
    end

    // ring data needs no reset; it only matters at a capture
    always_ff @(posedge clk_i)
    begin
        ring_s1_q <= io_ring_i;
        ring_s2_q <= ring_s1_q;
    end

    logic tck_rise;
    logic tck_fall;
    assign tck_rise = tck_s2_q & ~tck_prev_q;
    assign tck_fall = ~tck_s2_q & tck_prev_q;

    // -----------------------------------------------------------
    // controller
    // -----------------------------------------------------------
    sbst_ctl_if ctl ();
    assign ctl.tck_rise = tck_rise;
    assign ctl.tms = tms_s2_q;

    sbst_tap_fsm sbst_tap_fsm_i (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ctl(ctl.fsm)
    );

    sbst_state_t state;
    assign state = ctl.state;

    // -----------------------------------------------------------
    // scan registers
    // -----------------------------------------------------------
    logic [`SBST_IR_W-1:0] ir_sh_q;
    logic [`SBST_IR_W-1:0] ir_sh_d;
    logic [`SBST_IR_W-1:0] ir_q;
    logic [`SBST_IR_W-1:0] ir_d;
    logic [`SBST_ID_W-1:0] id_q;
    logic [`SBST_ID_W-1:0] id_d;
    logic [BSR_W-1:0] bsr_q;
    logic [BSR_W-1:0] bsr_d;
    logic byp_q;
    logic byp_d;
    sbst_path_t path;

    assign path = sbst_path(ir_q);

    always_comb
    begin
        ir_sh_d = ir_sh_q;
        ir_d = ir_q;
        id_d = id_q;
        bsr_d = bsr_q;
        byp_d = byp_q;
        if (state == ST_TLR)
            ir_d = `SBST_INS_IDCODE;
        if (tck_rise)
        begin
            case (state)
                ST_CAP_IR: ir_sh_d = `SBST_IR_CAPTURE;
                ST_SH_IR:
                    ir_sh_d = {tdi_s2_q, ir_sh_q[`SBST_IR_W-1:1]};
                ST_UPD_IR: ir_d = ir_sh_q;
                ST_CAP_DR:
                begin
                    // only the selected register captures
                    case (path)
                        PATH_BSR: bsr_d = ring_s2_q;
                        PATH_ID: id_d = ID_CODE;
                        PATH_BYP: byp_d = `SBST_BYP_CAPTURE;
                        default: byp_d = `SBST_BYP_CAPTURE;
                    endcase
                end
                ST_SH_DR:
                begin
                    // shift-in of preload bits rides on the shift-out
                    case (path)
                        PATH_BSR: bsr_d = {tdi_s2_q, bsr_q[BSR_W-1:1]};
                        PATH_ID: id_d = {tdi_s2_q, id_q[`SBST_ID_W-1:1]};
                        PATH_BYP: byp_d = tdi_s2_q;
                        default: byp_d = tdi_s2_q;
                    endcase
                end
                default: ir_d = ir_d;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            ir_sh_q <= `SBST_IR_CAPTURE;
            ir_q <= `SBST_INS_IDCODE;
            id_q <= `SBST_ID_CODE;
            bsr_q <= '0;
            byp_q <= `SBST_BYP_CAPTURE;
        end
        else
        begin
            ir_sh_q <= ir_sh_d;
            ir_q <= ir_d;
            id_q <= id_d;
            bsr_q <= bsr_d;
            byp_q <= byp_d;
        end
    end

    // -----------------------------------------------------------
    // serial output
    // -----------------------------------------------------------
    logic tdo_q;
    logic tdo_d;
    logic tdo_oe_q;
    logic tdo_oe_d;
    logic sel_bit;
    logic in_shift;

    assign in_shift = (state == ST_SH_IR) || (state == ST_SH_DR);

    always_comb
    begin
        if (state == ST_SH_IR)
            sel_bit = ir_sh_q[0];
        else
        begin
            case (path)
                PATH_BSR: sel_bit = bsr_q[0];
                PATH_ID: sel_bit = id_q[0];
                default: sel_bit = byp_q;
            endcase
        end
        tdo_d = tdo_q;
        tdo_oe_d = tdo_oe_q;
        if (tck_fall)
        begin
            tdo_oe_d = in_shift;
            if (in_shift)
                tdo_d = sel_bit;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            tdo_q <= `SBST_TDO_RESET;
            tdo_oe_q <= 1'h0;
        end
        else
        begin
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign tdo_o = tdo_q;
    assign tdo_oe_o = tdo_oe_q;
    // no preload path toward the memory; the ring is only observed
    assign mem_out_hiz_o = sbst_outputs_off(ir_q);

    // -----------------------------------------------------------
    // checks
    // -----------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_tdo_on_fall: assert property (
        $changed(tdo_o) |-> $past(tck_fall))
        else $error("serial output changed away from a tck fall");

    chk_oe_in_shift: assert property (
        $rose(tdo_oe_o) |-> $past(in_shift))
        else $error("serial output enabled outside a shift state");

    chk_powerup_off: assert property (
        !$past(resetn_i) |-> !tdo_oe_o && ir_q == `SBST_INS_IDCODE)
        else $error("serial output driven or wrong instruction after reset");

    chk_capir_pattern: assert property (
        tck_rise && state == ST_CAP_IR |=> ir_sh_q[1:0] == 2'h1)
        else $error("instruction capture did not load 01");

    chk_ir_update_only: assert property (
        $changed(ir_q) |-> ($past(state) == ST_UPD_IR && $past(tck_rise))
            || $past(state) == ST_TLR)
        else $error("instruction changed outside update or reset");

    chk_tlr_idcode: assert property (
        state == ST_TLR ##1 state == ST_TLR |-> ir_q == `SBST_INS_IDCODE)
        else $error("reset state did not select identification");

    chk_id_capture: assert property (
        tck_rise && state == ST_CAP_DR && path == PATH_ID
            |=> id_q == ID_CODE && id_q[0])
        else $error("identification capture wrong");

    chk_bypass_zero: assert property (
        tck_rise && state == ST_CAP_DR && path == PATH_BYP
            |=> byp_q == 1'h0 ##1 $stable(bsr_q))
        else $error("bypass capture wrong or boundary register disturbed");

    chk_bsr_shift_in: assert property (
        tck_rise && state == ST_SH_DR && path == PATH_BSR
            |=> bsr_q[BSR_W-1] == $past(tdi_s2_q)
            && bsr_q[BSR_W-2:0] == $past(bsr_q[BSR_W-1:1]))
        else $error("boundary register shift wrong");

    chk_zero_hiz: assert property (
        tck_rise && state == ST_UPD_IR && ir_sh_q == `SBST_INS_EXTEST
            |=> mem_out_hiz_o && path == PATH_BSR)
        else $error("all-zero instruction did not force outputs off");

    cov_shift_ir: cover property (
        tck_rise && state == ST_SH_IR);
    cov_id_shift: cover property (
        tck_rise && state == ST_SH_DR && path == PATH_ID);
    cov_bypass_shift: cover property (
        tck_rise && state == ST_SH_DR && path == PATH_BYP);
    cov_bsr_capture: cover property (
        tck_rise && state == ST_CAP_DR && path == PATH_BSR);

endmodule

`default_nettype wire

// ### sbst_defs.svh
// constants of the sram boundary-scan test port
// assumes nothing; included by the package and the design files
`ifndef SBST_DEFS_SVH
`define SBST_DEFS_SVH

// ---------------------------------------------------------------
// register widths
// ---------------------------------------------------------------
`define SBST_IR_W 3
`define SBST_ID_W 32
`define SBST_BSR_W 71

// ---------------------------------------------------------------
// instruction codes
// ---------------------------------------------------------------
`define SBST_INS_EXTEST 3'h0
`define SBST_INS_IDCODE 3'h1
`define SBST_INS_SAMPLE_Z 3'h2
`define SBST_INS_SAMPLE 3'h4
`define SBST_INS_BYPASS 3'h7

// ---------------------------------------------------------------
// capture and reset values
// ---------------------------------------------------------------
// upper bit zero, two low bits 01
`define SBST_IR_CAPTURE 3'h1
// arbitrary identification value, bit 0 set
`define SBST_ID_CODE 32'h1357_9BDF
`define SBST_BYP_CAPTURE 1'h0
`define SBST_TDO_RESET 1'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
// test-clock rises with mode select high that force reset
`define SBST_TMS_RESET_EDGES 3'h5

`endif

// ### sbst_pkg.sv
// types and decoders of the sram boundary-scan test port
// assumes sbst_defs.svh is on the include path
`default_nettype none
`include "sbst_defs.svh"

package sbst_pkg;

    // -----------------------------------------------------------
    // controller states
    // -----------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PA_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } sbst_state_t;

    typedef enum logic [1:0] {
        PATH_BSR, PATH_ID, PATH_BYP
    } sbst_path_t;

    // -----------------------------------------------------------
    // instruction decoding
    // -----------------------------------------------------------
    function automatic sbst_path_t sbst_path(
        input logic [`SBST_IR_W-1:0] ins
    );
        sbst_path_t p;
        case (ins)
            `SBST_INS_EXTEST: p = PATH_BSR;
            `SBST_INS_SAMPLE_Z: p = PATH_BSR;
            `SBST_INS_SAMPLE: p = PATH_BSR;
            `SBST_INS_IDCODE: p = PATH_ID;
            // reserved codes fall back to the bypass bit
            default: p = PATH_BYP;
        endcase
        return p;
    endfunction

    function automatic logic sbst_outputs_off(
        input logic [`SBST_IR_W-1:0] ins
    );
        return (ins == `SBST_INS_EXTEST) || (ins == `SBST_INS_SAMPLE_Z);
    endfunction

endpackage

`default_nettype wire

// ### sbst_ctl_if.sv
// link between the scan core and its controller state machine
// assumes both ends run on the same system clock
`timescale 1ns/1ns
`default_nettype none

interface sbst_ctl_if;
    logic tck_rise;
    logic tms;
    sbst_pkg::sbst_state_t state;

    modport fsm (
        input tck_rise,
        input tms,
        output state
    );
    modport core (
        output tck_rise,
        output tms,
        input state
    );
endinterface

`default_nettype wire

// ### sbst_tap_fsm.sv
// sixteen-state test access controller
// assumes tck_rise is a one-cycle pulse and tms is already synchronised
`timescale 1ns/1ns
`default_nettype none
`include "sbst_defs.svh"

module sbst_tap_fsm
    import sbst_pkg::*;
(
    // system
    input wire logic clk_i,
    input wire logic resetn_i,
    // controller link
    sbst_ctl_if.fsm ctl
);

    sbst_state_t state_q;
    sbst_state_t state_d;

    // -----------------------------------------------------------
    // next state
    // -----------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        if (ctl.tck_rise)
        begin
            case (state_q)
                ST_TLR: state_d = ctl.tms ? ST_TLR : ST_RTI;
                ST_RTI: state_d = ctl.tms ? ST_SEL_DR : ST_RTI;
                ST_SEL_DR: state_d = ctl.tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: state_d = ctl.tms ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR: state_d = ctl.tms ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: state_d = ctl.tms ? ST_UPD_DR : ST_PA_DR;
                ST_PA_DR: state_d = ctl.tms ? ST_EX2_DR : ST_PA_DR;
                ST_EX2_DR: state_d = ctl.tms ? ST_UPD_DR : ST_SH_DR;
                ST_UPD_DR: state_d = ctl.tms ? ST_SEL_DR : ST_RTI;
                // five high rises from anywhere end here
                ST_SEL_IR: state_d = ctl.tms ? ST_TLR : ST_CAP_IR;
                ST_CAP_IR: state_d = ctl.tms ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR: state_d = ctl.tms ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: state_d = ctl.tms ? ST_UPD_IR : ST_PA_IR;
                ST_PA_IR: state_d = ctl.tms ? ST_EX2_IR : ST_PA_IR;
                ST_EX2_IR: state_d = ctl.tms ? ST_UPD_IR : ST_SH_IR;
                ST_UPD_IR: state_d = ctl.tms ? ST_SEL_DR : ST_RTI;
                default: state_d = ST_TLR;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            state_q <= ST_TLR;
        else
            state_q <= state_d;
    end

    assign ctl.state = state_q;

    // -----------------------------------------------------------
    // checks
    // -----------------------------------------------------------
    logic [2:0] high_cnt_q;
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            high_cnt_q <= 3'h0;
        else if (ctl.tck_rise)
            high_cnt_q <= !ctl.tms ? 3'h0 :
                (high_cnt_q == `SBST_TMS_RESET_EDGES) ? high_cnt_q :
                high_cnt_q + 3'h1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_five_high_reset: assert property (
        high_cnt_q == `SBST_TMS_RESET_EDGES |-> state_q == ST_TLR)
        else $error("five tms-high rises did not reach reset state");

    chk_state_on_rise: assert property (
        !ctl.tck_rise |=> $stable(state_q))
        else $error("controller state moved without a tck rise");

endmodule

`default_nettype wire

// ### sbst_scan_host.sv
// scan controller model that drives the test port pins of the block
// assumes the system clock runs eight times the test-clock rate
`timescale 1ns/1ns
`default_nettype none

module sbst_scan_host
(
    // system
    input wire logic clk_i,
    // test port pins
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    int tdo_moves = 0;
    logic tck_n;
    logic tdo_n;

    // pins idle: clock low, pulled-up lines high
    initial
    begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h1;
    end

    // ------------------------------------------------------------
    // watch for tdo moving while the test clock is high
    // ------------------------------------------------------------
    always @(negedge clk_i)
    begin
        if (tck_o && tck_n && tdo_i !== tdo_n)
            tdo_moves++;
        tck_n <= tck_o;
        tdo_n <= tdo_i;
    end

    // ------------------------------------------------------------
    // pin sequences
    // ------------------------------------------------------------
    // one 800 ns period: fall, four cycles low, rise, four high
    task automatic step(input logic tms, input logic tdi,
                        output logic tdo, output logic oe);
        @(posedge clk_i);
        tck_o <= 1'h0;
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (4) @(posedge clk_i);
        tck_o <= 1'h1;
        @(negedge clk_i);
        // an undriven line reads back as garbage, here the inverse
        tdo = tdo_oe_i ? tdo_i : ~tdo_i;
        oe = tdo_oe_i;
        repeat (3) @(posedge clk_i);
    endtask

    // clock stands still low between frames, lines released high
    task automatic idle();
        @(posedge clk_i);
        tck_o <= 1'h0;
        tms_o <= 1'h1;
        tdi_o <= 1'h1;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic reset5();
        logic t;
        logic e;
        repeat (5) step(1'h1, 1'h1, t, e);
        step(1'h0, 1'h1, t, e);
        idle();
    endtask

    // run-test-idle, one shift pass, update, back to run-test-idle
    task automatic scan(input logic ir, input int n,
                        input logic [127:0] din,
                        output logic [127:0] dout, output int oe_bad);
        logic t;
        logic e;
        dout = '0;
        oe_bad = 0;
        step(1'h1, 1'h1, t, e);
        if (ir)
            step(1'h1, 1'h1, t, e);
        step(1'h0, 1'h1, t, e);
        step(1'h0, 1'h1, t, e);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], dout[i], e);
            if (e !== 1'h1)
                oe_bad++;
        end
        step(1'h1, 1'h1, t, e);
        step(1'h0, 1'h1, t, e);
        idle();
    endtask
endmodule

`default_nettype wire

// ### test_sbst_tap.sv
// self-checking bench of the sram boundary-scan test port
// assumes the scan controller model drives the test pins
`timescale 1ns/1ns
`default_nettype none
`include "sbst_defs.svh"

module test_sbst_tap;
    localparam int BSR_W = `SBST_BSR_W;
    // arbitrary identification value, bit 0 set
    localparam logic [31:0] ID_EXP = 32'h2468_ACE1;
    localparam logic [70:0] RING = 71'h5A_C3A5_0F1E_9B7D_2468;

    logic clk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_o;
    logic tdo_oe_o;
    logic mem_out_hiz_o;
    logic [BSR_W-1:0] io_ring_i = '0;
    int mismatches = 0;
    int tests_run = 0;

    sbst_tap #(.BSR_W(BSR_W), .ID_CODE(ID_EXP)) sbst_tap_i (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tck_i(tck),
        .tms_i(tms),
        .tdi_i(tdi),
        .tdo_o(tdo_o),
        .tdo_oe_o(tdo_oe_o),
        .io_ring_i(io_ring_i),
        .mem_out_hiz_o(mem_out_hiz_o)
    );

    sbst_scan_host sbst_scan_host_i (
        .clk_i(clk_i),
        .tck_o(tck),
        .tms_o(tms),
        .tdi_o(tdi),
        .tdo_i(tdo_o),
        .tdo_oe_i(tdo_oe_o)
    );

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic cmp_bit(input string what, input logic exp,
                           input logic got);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s exp=%b got=%b", what, exp, got);
        end
    endtask

    task automatic cmp_vec(input string what, input logic [127:0] exp,
                           input logic [127:0] got);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s exp=%h got=%h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic load_ir(input logic [2:0] code);
        logic [127:0] d;
        int bad;
        sbst_scan_host_i.scan(1'h1, 3, {125'h0, code}, d, bad);
        cmp_vec("ir capture", 128'h1, d);
        cmp_bit("ir tdo_oe", 1'h1, bad == 0);
    endtask

    task automatic read_dr(input int n, input logic [127:0] din,
                           output logic [127:0] dout);
        int bad;
        sbst_scan_host_i.scan(1'h0, n, din, dout, bad);
        cmp_bit("dr tdo_oe", 1'h1, bad == 0);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power_up();
        cmp_bit("tdo_oe reset", 1'h0, tdo_oe_o);
        cmp_bit("hiz reset", 1'h0, mem_out_hiz_o);
    endtask

    task automatic t_tap_reset();
        logic [127:0] d;
        load_ir(`SBST_INS_EXTEST);
        cmp_bit("hiz extest", 1'h1, mem_out_hiz_o);
        sbst_scan_host_i.reset5();
        cmp_bit("hiz after reset", 1'h0, mem_out_hiz_o);
        read_dr(40, 128'hA5, d);
        cmp_vec("idcode", {88'h0, 8'hA5, ID_EXP}, d);
        cmp_bit("id bit0", 1'h1, d[0]);
    endtask

    // reserved codes are never loaded by a well-behaved controller
    task automatic t_bypass();
        logic [127:0] d;
        load_ir(`SBST_INS_BYPASS);
        read_dr(8, 128'hB6, d);
        cmp_vec("bypass path", 128'h6C, d);
        cmp_bit("bypass hiz", 1'h0, mem_out_hiz_o);
    endtask

    task automatic t_boundary();
        logic [2:0] codes [3] = '{`SBST_INS_EXTEST, `SBST_INS_SAMPLE_Z,
                                  `SBST_INS_SAMPLE};
        logic [127:0] d;
        foreach (codes[k])
        begin
            io_ring_i <= RING >> k;
            load_ir(codes[k]);
            cmp_bit("outputs off", codes[k] != `SBST_INS_SAMPLE,
                    mem_out_hiz_o);
            read_dr(79, 128'hC4, d);
            cmp_vec("ring", {49'h0, 8'hC4, RING >> k}, d);
            cmp_vec("shift in", 128'hC4, d[127:71]);
        end
    endtask

    // new code shifted in must wait for the update state
    task automatic t_update_only();
        logic t;
        logic e;
        load_ir(`SBST_INS_EXTEST);
        sbst_scan_host_i.step(1'h1, 1'h1, t, e);
        sbst_scan_host_i.step(1'h1, 1'h1, t, e);
        sbst_scan_host_i.step(1'h0, 1'h1, t, e);
        sbst_scan_host_i.step(1'h0, 1'h1, t, e);
        sbst_scan_host_i.step(1'h0, 1'h1, t, e);
        sbst_scan_host_i.step(1'h0, 1'h1, t, e);
        sbst_scan_host_i.step(1'h1, 1'h1, t, e);
        repeat (4) @(posedge clk_i);
        cmp_bit("hiz before update", 1'h1, mem_out_hiz_o);
        sbst_scan_host_i.step(1'h1, 1'h1, t, e);
        sbst_scan_host_i.step(1'h0, 1'h1, t, e);
        sbst_scan_host_i.idle();
        cmp_bit("hiz after update", 1'h0, mem_out_hiz_o);
        cmp_bit("tdo_oe idle", 1'h0, tdo_oe_o);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_i);
        t_power_up();
        resetn_i <= 1'h1;
        @(posedge clk_i);
        t_power_up();
        sbst_scan_host_i.reset5();
        t_tap_reset();
        t_bypass();
        t_boundary();
        t_update_only();
        cmp_bit("tdo steady high", 1'h1,
                sbst_scan_host_i.tdo_moves == 0);
        print_verdict();
    end

    initial
    begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end
endmodule

`default_nettype wire
